/* File: logic/adc_result_autotrigger.sv */
// converter result readout, result formatting and auto-trigger control
//
// Overview of operation
// - low byte read freezes the result register
// - align select one left-aligns, zero right-aligns
// - ten-bit result spread over two bytes
// - unipolar: negative difference saturates to reference
// - unipolar result is ten unsigned bits
// - bipolar result is two's complement, sign+9
// - polarity reverse swaps the differential pair
// - bits 4:3 of status B read zero
// - trigger field acts only with auto-trigger
// - selected flag rising edge starts conversion
// - switching from a clear flag onto a set flag is edge
// - switching to free running never triggers
// - trigger field decodes seven documented sources
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "adc_result_defines.svh"
module adc_result_autotrigger
   import adc_result_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // conversion core
   input  wire logic        sampleValid,
   input  wire logic [9:0]  sampleMagnitude,
   input  wire logic        sampleBelow,
   input  wire logic        converterFlag,
   // trigger event flags, source 1 upward
   input  wire logic [5:0]  eventFlags,
   // analogue front end control
   output logic             startConversion,
   output logic             inputSwap,
   output logic             bipolarMode,
   output logic             comparatorMuxEnable
);

   // ============================================================
   // declarations
   logic [31:0]  prdata_reg;
   logic [31:0]  prdata_next;
   logic         pready_reg;
   logic         pslverr_reg;
   logic         pslverr_next;
   logic         accessDone;
   logic         accessWait;
   logic         writeLow;
   logic [5:0]   regIndex;
   logic         mappedIndex;

   logic         converterEnable_reg;
   logic         autoTrigger_reg;
   logic         leftAlign_reg;
   logic         manualStart;

   logic         bipolar_reg;
   logic         comparatorMux_reg;
   logic         polarityReverse_reg;
   trigger_sel_t triggerSource_reg;

   result_t      result_reg;
   result_t      result_next;
   logic         locked_reg;
   logic         sampleLost_reg;
   logic         resultValid_reg;
   logic         effectiveBelow;
   logic [8:0]   halfMagnitude;

   byte_t        resultHigh;
   byte_t        resultLow;
   byte_t        controlRead;
   byte_t        statusRead;
   byte_t        statusBRead;

   logic         readLow;
   logic         readHigh;
   logic         clearLost;
   logic         startConversion_reg;
   logic         inputSwap_reg;
   logic         bipolarMode_reg;
   logic         comparatorMuxEnable_reg;

   trigger_if    trig ();

   // ============================================================
   // apb handshake: one wait state, answer in second access cycle
   assign regIndex    = paddr[7:2];
   assign accessWait  = psel && penable && !pready_reg;
   assign accessDone  = psel && penable && pready_reg;
   assign writeLow    = accessDone && pwrite && pstrb[0];

   always_comb begin
      mappedIndex = 1'b0;
      unique case (regIndex)
         `IDX_CONTROL,
         `IDX_STATUS,
         `IDX_CTRL_STATUS_B,
         `IDX_RESULT_LOW,
         `IDX_RESULT_HIGH: mappedIndex = 1'b1;
         default:          mappedIndex = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= accessWait;
      end
   end

   // ============================================================
   // read data views
   always_comb begin
      controlRead = 8'h00;
      controlRead[`CTL_CONVERTER_ENABLE] = converterEnable_reg;
      controlRead[`CTL_AUTO_TRIGGER]     = autoTrigger_reg;
      controlRead[`CTL_LEFT_ALIGN]       = leftAlign_reg;
   end

   always_comb begin
      statusRead = 8'h00;
      statusRead[`STA_LOCKED]       = locked_reg;
      statusRead[`STA_SAMPLE_LOST]  = sampleLost_reg;
      statusRead[`STA_RESULT_VALID] = resultValid_reg;
   end

   // reserved bits 4:3 stay zero
   always_comb begin
      statusBRead = 8'h00;
      statusBRead[`CSB_BIPOLAR]          = bipolar_reg;
      statusBRead[`CSB_COMPARATOR_MUX]   = comparatorMux_reg;
      statusBRead[`CSB_POLARITY_REVERSE] = polarityReverse_reg;
      statusBRead[`CSB_TRIGGER_HI:`CSB_TRIGGER_LO] = triggerSource_reg;
   end

   // alignment applied on the way out
   always_comb begin
      if (leftAlign_reg) begin
         resultHigh = result_reg[9:2];
         resultLow  = {result_reg[1:0], 6'h00};
      end else begin
         resultHigh = {6'h00, result_reg[9:8]};
         resultLow  = result_reg[7:0];
      end
   end

   always_comb begin
      prdata_next = 32'h0000_0000;
      unique case (regIndex)
         `IDX_CONTROL:       prdata_next[7:0] = controlRead;
         `IDX_STATUS:        prdata_next[7:0] = statusRead;
         `IDX_CTRL_STATUS_B: prdata_next[7:0] = statusBRead;
         `IDX_RESULT_LOW:    prdata_next[7:0] = resultLow;
         `IDX_RESULT_HIGH:   prdata_next[7:0] = resultHigh;
         default:            prdata_next = 32'h0000_0000;
      endcase
   end

   assign pslverr_next = !mappedIndex;

   // data and error are registered on the same edge that raises pready
   always_ff @(posedge clock) begin
      if (!resetn) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (accessWait) begin
         prdata_reg  <= pwrite ? 32'h0000_0000 : prdata_next;
         pslverr_reg <= pslverr_next;
      end else if (accessDone) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
   end

   // ============================================================
   // control register
   assign manualStart = writeLow && regIndex == `IDX_CONTROL && pwdata[`CTL_START];

   always_ff @(posedge clock) begin
      if (!resetn) begin
         {leftAlign_reg, autoTrigger_reg, converterEnable_reg} <= `CTL_RESET_VALUE;
      end else if (writeLow && regIndex == `IDX_CONTROL) begin
         converterEnable_reg <= pwdata[`CTL_CONVERTER_ENABLE];
         autoTrigger_reg     <= pwdata[`CTL_AUTO_TRIGGER];
         leftAlign_reg       <= pwdata[`CTL_LEFT_ALIGN];
      end
   end

   // ============================================================
   // converter_control_status_b
   always_ff @(posedge clock) begin
      if (!resetn) begin
         bipolar_reg         <= 1'b0;
         comparatorMux_reg   <= 1'b0;
         polarityReverse_reg <= 1'b0;
         triggerSource_reg   <= `TRIGGER_FREE_RUNNING;
      end else if (writeLow && regIndex == `IDX_CTRL_STATUS_B) begin
         bipolar_reg         <= pwdata[`CSB_BIPOLAR];
         comparatorMux_reg   <= pwdata[`CSB_COMPARATOR_MUX];
         polarityReverse_reg <= pwdata[`CSB_POLARITY_REVERSE];
         triggerSource_reg   <= pwdata[`CSB_TRIGGER_HI:`CSB_TRIGGER_LO];
      end
   end

   // ============================================================
   // result formatting
   assign effectiveBelow = sampleBelow ^ polarityReverse_reg;
   assign halfMagnitude  = sampleMagnitude[9:1];

   always_comb begin
      if (bipolar_reg) begin
         // sign plus nine magnitude bits
         result_next = effectiveBelow ? result_t'(~{1'b0, halfMagnitude} + 10'h001)
                                      : {1'b0, halfMagnitude};
      end else if (effectiveBelow) begin
         result_next = `RESULT_SATURATED;
      end else begin
         result_next = sampleMagnitude;
      end
   end

   // ============================================================
   // result lock between low and high reads
   assign readLow   = accessDone && !pwrite && regIndex == `IDX_RESULT_LOW;
   assign readHigh  = accessDone && !pwrite && regIndex == `IDX_RESULT_HIGH;
   assign clearLost = writeLow && regIndex == `IDX_STATUS && pwdata[`STA_SAMPLE_LOST];

   always_ff @(posedge clock) begin
      if (!resetn) begin
         locked_reg <= 1'b0;
      end else if (readHigh) begin
         locked_reg <= 1'b0;
      end else if (readLow) begin
         locked_reg <= 1'b1;
      end
   end

   // a sample arriving while locked is dropped
   always_ff @(posedge clock) begin
      if (!resetn) begin
         result_reg      <= `RESULT_RESET_VALUE;
         resultValid_reg <= 1'b0;
      end else if (sampleValid && !locked_reg) begin
         result_reg      <= result_next;
         resultValid_reg <= 1'b1;
      end
   end

   // sticky, write one to clear, a new loss wins
   always_ff @(posedge clock) begin
      if (!resetn) begin
         sampleLost_reg <= 1'b0;
      end else if (sampleValid && locked_reg) begin
         sampleLost_reg <= 1'b1;
      end else if (clearLost) begin
         sampleLost_reg <= 1'b0;
      end
   end

   // ============================================================
   // auto-trigger selection
   assign trig.sourceSelect    = triggerSource_reg;
   assign trig.autoEnable      = autoTrigger_reg;
   assign trig.converterEnable = converterEnable_reg;
   assign trig.converterFlag   = converterFlag;
   assign trig.eventFlags      = eventFlags;

   trigger_select #(
      .SOURCE_COUNT (6)
   ) u_trigger_select (
      .clock  (clock),
      .resetn (resetn),
      .trig   (trig)
   );

   // ============================================================
   // front end outputs
   always_ff @(posedge clock) begin
      if (!resetn) begin
         startConversion_reg <= 1'b0;
      end else begin
         startConversion_reg <= trig.autoStart || (manualStart && converterEnable_reg);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         inputSwap_reg           <= 1'b0;
         bipolarMode_reg         <= 1'b0;
         comparatorMuxEnable_reg <= 1'b0;
      end else begin
         inputSwap_reg           <= polarityReverse_reg;
         bipolarMode_reg         <= bipolar_reg;
         comparatorMuxEnable_reg <= comparatorMux_reg;
      end
   end

   // ============================================================
   // outputs
   assign prdata              = prdata_reg;
   assign pready              = pready_reg;
   assign pslverr             = pslverr_reg;
   assign startConversion     = startConversion_reg;
   assign inputSwap           = inputSwap_reg;
   assign bipolarMode         = bipolarMode_reg;
   assign comparatorMuxEnable = comparatorMuxEnable_reg;

endmodule : adc_result_autotrigger

/* File: logic/adc_result_defines.svh */
// register indices, field positions, reset values and constants of the result block
`ifndef ADC_RESULT_DEFINES_SVH
`define ADC_RESULT_DEFINES_SVH

// ============================================================
// register indices (byte address is four times the index)
`define IDX_CONTROL         6'h00
`define IDX_STATUS          6'h01
`define IDX_CTRL_STATUS_B   6'h03
`define IDX_RESULT_LOW      6'h04
`define IDX_RESULT_HIGH     6'h05

// ============================================================
// control register fields
`define CTL_CONVERTER_ENABLE   0
`define CTL_AUTO_TRIGGER       1
`define CTL_LEFT_ALIGN         2
`define CTL_START              3
`define CTL_RESET_VALUE        3'h0

// ============================================================
// status register fields
`define STA_LOCKED             0
`define STA_SAMPLE_LOST        1
`define STA_RESULT_VALID       2

// ============================================================
// converter_control_status_b fields
`define CSB_BIPOLAR            7
`define CSB_COMPARATOR_MUX     6
`define CSB_POLARITY_REVERSE   5
`define CSB_TRIGGER_HI         2
`define CSB_TRIGGER_LO         0
`define CSB_RESET_VALUE        8'h00

// ============================================================
// result constants
`define RESULT_RESET_VALUE     10'h000
`define RESULT_SATURATED       10'h3FF
`define TRIGGER_FREE_RUNNING   3'h0

`endif

/* File: logic/adc_result_pkg.sv */
// types shared by the result and trigger logic
package adc_result_pkg;

   typedef logic [2:0] trigger_sel_t;
   typedef logic [9:0] result_t;
   typedef logic [7:0] byte_t;

endpackage : adc_result_pkg

/* File: logic/trigger_if.sv */
// carrier between the register logic and the trigger selector
`timescale 1ns/1ps
interface trigger_if;
   import adc_result_pkg::*;

   trigger_sel_t sourceSelect;
   logic         autoEnable;
   logic         converterEnable;
   logic         converterFlag;
   logic [5:0]   eventFlags;
   logic         autoStart;

   modport ctrl (
      output sourceSelect,
      output autoEnable,
      output converterEnable,
      output converterFlag,
      output eventFlags,
      input  autoStart
   );

   modport sel (
      input  sourceSelect,
      input  autoEnable,
      input  converterEnable,
      input  converterFlag,
      input  eventFlags,
      output autoStart
   );

endinterface : trigger_if

/* File: logic/trigger_select.sv */
// auto-trigger source multiplexer with rising-edge detection
`timescale 1ns/1ps
`include "adc_result_defines.svh"
module trigger_select
   import adc_result_pkg::*;
#(
   parameter int SOURCE_COUNT = 6
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // selector side
   trigger_if.sel   trig
);

   logic [SOURCE_COUNT:0] sourceLine;
   logic                  selectedFlag;
   logic                  selectedFlag_reg;
   trigger_sel_t          sourceSelect_reg;
   logic                  risingEdge;
   logic                  autoStart_reg;

   // ============================================================
   // source lines
   assign sourceLine[0] = trig.converterFlag;
   for (genvar i = 1; i <= SOURCE_COUNT; i++) begin : gen_source
      assign sourceLine[i] = trig.eventFlags[i-1];
   end

   // codes beyond the table select nothing
   always_comb begin
      selectedFlag = 1'b0;
      if (int'(trig.sourceSelect) <= SOURCE_COUNT) begin
         selectedFlag = sourceLine[trig.sourceSelect];
      end
   end

   // ============================================================
   // edge detection
   always_ff @(posedge clock) begin
      if (!resetn) begin
         selectedFlag_reg <= 1'b0;
         sourceSelect_reg <= `TRIGGER_FREE_RUNNING;
      end else begin
         selectedFlag_reg <= selectedFlag;
         sourceSelect_reg <= trig.sourceSelect;
      end
   end

   // a switch from a clear flag onto a set flag is an edge, except a switch into free running
   assign risingEdge = selectedFlag && !selectedFlag_reg
                       && !(trig.sourceSelect == `TRIGGER_FREE_RUNNING
                            && sourceSelect_reg != `TRIGGER_FREE_RUNNING);

   always_ff @(posedge clock) begin
      if (!resetn) begin
         autoStart_reg <= 1'b0;
      end else begin
         autoStart_reg <= risingEdge && trig.autoEnable && trig.converterEnable;
      end
   end

   assign trig.autoStart = autoStart_reg;

endmodule : trigger_select

/* File: tb/adc_result_autotrigger_properties.sv */
// port checker of the result and auto-trigger block
`timescale 1ns/1ps
module adc_result_autotrigger_properties (
   // clock and reset
   input wire logic        clock,
   input wire logic        resetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   // trigger and front end
   input wire logic        converterFlag,
   input wire logic [5:0]  eventFlags,
   input wire logic        startConversion,
   input wire logic        inputSwap,
   input wire logic        bipolarMode
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   // ==========================================
   // shadow of the software-visible state
   wire logic       done = psel & penable & pready;
   wire logic [5:0] idx  = paddr[7:2];
   wire logic       rd   = done & !pwrite;
   wire logic       wrB  = done & pwrite & pstrb[0] & (idx == 6'h03);
   wire logic       wrC  = done & pwrite & pstrb[0] & (idx == 6'h00);
   wire logic       manSt = wrC & pwdata[3];
   logic            lockReg;
   logic            alignReg;
   logic            autoReg;
   logic            enReg;
   logic [2:0]      srcReg;
   wire logic       selFlag = (srcReg == 3'h0) ? converterFlag :
                              (srcReg == 3'h7) ? 1'b0 : eventFlags[srcReg - 3'h1];

   always_ff @(posedge clock) begin
      if (!resetn) begin
         lockReg <= 1'b0;
         {alignReg, autoReg, enReg} <= 3'h0;
         srcReg <= 3'h0;
      end else begin
         if (rd && idx == 6'h04) lockReg <= 1'b1;
         if (rd && idx == 6'h05) lockReg <= 1'b0;
         if (wrC) {alignReg, autoReg, enReg} <= pwdata[2:0];
         if (wrB) srcReg <= pwdata[2:0];
      end
   end

   // ==========================================
   // properties
   property p_reserved_zero; rd && idx == 6'h03 |-> prdata[4:3] == 2'h0; endproperty
   // stored bit lands one cycle after the write, the pin one cycle later
   property p_swap; wrB |-> ##2 inputSwap == $past(pwdata[5], 2); endproperty
   property p_bipolar; wrB |-> ##2 bipolarMode == $past(pwdata[7], 2); endproperty
   property p_lock; rd && idx == 6'h01 |-> prdata[0] == lockReg; endproperty
   property p_right; rd && idx == 6'h05 && !alignReg |-> prdata[7:2] == 6'h00; endproperty
   property p_left; rd && idx == 6'h04 && alignReg |-> prdata[5:0] == 6'h00; endproperty
   property p_edge;
      autoReg && enReg && srcReg != 3'h0 && $stable(srcReg) && $rose(selFlag) |-> ##2 startConversion;
   endproperty
   property p_free; wrB && pwdata[2:0] == 3'h0 && srcReg != 3'h0 |=> !startConversion [*3]; endproperty
   property p_cause; startConversion |-> enReg && (autoReg || $past(manSt)); endproperty

   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
   a_swap: assert property (p_swap) else $error("input swap not following bit 5");
   a_bipolar: assert property (p_bipolar) else $error("bipolar mode not following bit 7");
   a_lock: assert property (p_lock) else $error("lock flag wrong");
   a_right: assert property (p_right) else $error("right aligned high byte not zero filled");
   a_left: assert property (p_left) else $error("left aligned low byte not zero filled");
   a_edge: assert property (p_edge) else $error("flag edge gave no start");
   a_free: assert property (p_free) else $error("free running select started");
   a_cause: assert property (p_cause) else $error("start without enable");

   c_start: cover property (startConversion);
   c_locked_high: cover property (rd && idx == 6'h05 && lockReg);
   c_free: cover property (wrB && pwdata[2:0] == 3'h0 && srcReg != 3'h0);
endmodule : adc_result_autotrigger_properties

bind adc_result_autotrigger adc_result_autotrigger_properties adc_result_autotrigger_properties_i (
   .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
   .converterFlag, .eventFlags, .startConversion, .inputSwap, .bipolarMode);

/* File: tb/test_adc_result_autotrigger.sv */
// self-checking bench of the result and auto-trigger block
`timescale 1ns/1ps
`include "adc_result_defines.svh"
module test_adc_result_autotrigger;
   import adc_result_pkg::*;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sampleValid = 1'b0;
   logic [9:0]  sampleMagnitude = 10'h000;
   logic        sampleBelow = 1'b0;
   logic        converterFlag = 1'b0;
   logic [5:0]  eventFlags = 6'h00;
   logic        startConversion, inputSwap, bipolarMode, comparatorMuxEnable;
   logic [31:0] rdata;
   logic        rerr;
   int          err_count = 0;
   int          num_checks = 0;
   int          starts = 0;
   int          n0;
   logic [9:0]  mag;

   always #50 clock = ~clock;
   always @(posedge clock) if (startConversion === 1'b1) starts <= starts + 1;

   adc_result_autotrigger adc_result_autotrigger_i (
      .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .sampleValid, .sampleMagnitude, .sampleBelow, .converterFlag, .eventFlags,
      .startConversion, .inputSwap, .bipolarMode, .comparatorMuxEnable);

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdata);
   endtask : rd

   task automatic sample(input logic [9:0] m, input logic b);
      @(posedge clock);
      sampleValid <= 1'b1;
      sampleMagnitude <= m;
      sampleBelow <= b;
      @(posedge clock);
      sampleValid <= 1'b0;
   endtask : sample

   function automatic result_t fmt(input logic [9:0] m, input logic b, input logic p, input logic bip);
      logic [9:0] v;
      v = {1'b0, m[9:1]};
      if (!bip) return (b ^ p) ? `RESULT_SATURATED : m;
      return (b ^ p) ? -v : v;
   endfunction : fmt

   function automatic logic [31:0] part(input result_t r, input logic la, input logic high);
      if (high) return la ? {24'h0, r[9:2]} : {30'h0, r[9:8]};
      return la ? {24'h0, r[1:0], 6'h00} : {24'h0, r[7:0]};
   endfunction : part

   task automatic rres(input result_t r, input logic la);
      rd(8'h10, part(r, la, 1'b0), "result low");
      rd(8'h14, part(r, la, 1'b1), "result high");
   endtask : rres

   initial begin
      repeat (5000) @(posedge clock);
      err_count++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(43033));
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      // ==========================================
      // reset values, reserved bits, unmapped index
      rd(8'h00, 32'h0, "control");
      rd(8'h0C, 32'h0, "status b");
      rres(10'h000, 1'b0);
      apb(1'b1, 8'h0C, 32'hFF);
      rd(8'h0C, 32'hE7, "status b");
      chk("front end", 32'h7, {29'h0, inputSwap, bipolarMode, comparatorMuxEnable});
      apb(1'b0, 8'h08, 32'h0);
      chk("pslverr", 32'h1, {31'h0, rerr});
      $display("test registers done");
      // ==========================================
      // every format and alignment combination
      for (int i = 0; i < 16; i++) begin
         mag = (i == 0) ? 10'h3FF : 10'($urandom);
         apb(1'b1, 8'h0C, {24'h0, i[3], 1'b0, i[2], 5'h00});
         apb(1'b1, 8'h00, {29'h0, i[1], 2'b00});
         sample(mag, i[0]);
         rres(fmt(mag, i[0], i[2], i[3]), i[1]);
      end
      $display("test formats done");
      // ==========================================
      // lock between low and high reads
      apb(1'b1, 8'h0C, 32'h0);
      apb(1'b1, 8'h00, 32'h4);
      sample(10'h155, 1'b0);
      rd(8'h10, part(10'h155, 1'b1, 1'b0), "result low");
      sample(10'h2AA, 1'b0);
      rd(8'h04, 32'h7, "status");
      rd(8'h14, part(10'h155, 1'b1, 1'b1), "result high");
      rd(8'h04, 32'h6, "status");
      apb(1'b1, 8'h04, 32'h2);
      rd(8'h04, 32'h4, "status");
      sample(10'h2AA, 1'b0);
      rd(8'h14, part(10'h2AA, 1'b1, 1'b1), "result high");
      $display("test lock done");
      // ==========================================
      // trigger sources
      apb(1'b1, 8'h00, 32'h3);
      for (int s = 1; s < 7; s++) begin
         eventFlags <= 6'h00;
         apb(1'b1, 8'h0C, 32'(s));
         n0 = starts;
         @(posedge clock);
         eventFlags[s - 1] <= 1'b1;
         repeat (5) @(posedge clock);
         chk("starts", 32'(n0 + 1), 32'(starts));
      end
      eventFlags <= 6'h02;
      apb(1'b1, 8'h0C, 32'h1);
      n0 = starts;
      apb(1'b1, 8'h0C, 32'h2);
      repeat (4) @(posedge clock);
      chk("starts", 32'(n0 + 1), 32'(starts));
      eventFlags <= 6'h00;
      converterFlag <= 1'b1;
      apb(1'b1, 8'h0C, 32'h1);
      n0 = starts;
      apb(1'b1, 8'h0C, 32'h0);
      repeat (4) @(posedge clock);
      chk("starts", 32'(n0), 32'(starts));
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h0C, 32'h1);
      n0 = starts;
      eventFlags <= 6'h01;
      repeat (4) @(posedge clock);
      chk("starts", 32'(n0), 32'(starts));
      // software start still works with the trigger field ignored
      n0 = starts;
      apb(1'b1, 8'h00, 32'h9);
      repeat (3) @(posedge clock);
      chk("starts", 32'(n0 + 1), 32'(starts));
      // code seven selects no source at all
      apb(1'b1, 8'h00, 32'h3);
      eventFlags <= 6'h3E;
      n0 = starts;
      apb(1'b1, 8'h0C, 32'h7);
      eventFlags <= 6'h3F;
      repeat (4) @(posedge clock);
      chk("starts", 32'(n0), 32'(starts));
      $display("test triggers done");
      tally_and_finish();
   end
endmodule : test_adc_result_autotrigger
